// file: core/vfd_pkg.sv
// Constants, field layout and state types of the display controller
package vfd_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned RAM_BYTES   = 36;
  localparam int unsigned KEY_BITS    = 32;
  localparam int unsigned STROBES     = 16;
  localparam int unsigned SHARED_PINS = 8;
  localparam int unsigned GRID_PINS   = 4;
  localparam int unsigned LED_PINS    = 4;
  localparam int unsigned ROW_BYTES   = 3;
  localparam int          GRID_TOP    = 11;

  // ****************************************************************
  // Command byte layout (type in bits 7:6)
  // ****************************************************************
  localparam int          CMD_HI       = 7;
  localparam int          CMD_LO       = 6;
  localparam logic [1:0]  CMD_MODE     = 2'h0;
  localparam logic [1:0]  CMD_DATA     = 2'h1;
  localparam logic [1:0]  CMD_CTRL     = 2'h2;
  localparam logic [1:0]  CMD_ADDR     = 2'h3;
  localparam int          MODE_HI      = 3;
  localparam int          OP_HI        = 1;
  localparam int          FIXED_BIT    = 2;
  localparam int          ON_BIT       = 3;
  localparam int          DIM_HI       = 2;
  localparam int          ADDR_HI      = 5;
  localparam int          LED_HI       = 3;
  localparam logic [1:0]  OP_WRITE_RAM = 2'h0;
  localparam logic [1:0]  OP_WRITE_LED = 2'h1;
  localparam logic [1:0]  OP_READ_KEY  = 2'h2;

  // ****************************************************************
  // Modes, limits and reset values
  // ****************************************************************
  localparam logic [3:0]  MODE_MAX     = 4'h8;  // Twelve digits, sixteen segments
  localparam logic [3:0]  MODE_RESET   = 4'h8;
  localparam logic [3:0]  DIG_BASE     = 4'h4;
  localparam logic [5:0]  ADDR_LIMIT   = 6'h24;
  localparam logic [5:0]  ADDR_RESET   = 6'h00;
  localparam logic [2:0]  DIM_RESET    = 3'h0;
  localparam logic [3:0]  LED_RESET    = 4'hf;
  localparam logic [3:0]  SEC_LAST     = 4'hf;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [15:0] STROBE_ONE   = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_GRID = 3'b010,
    ST_KEY  = 3'b100
  } vfd_scan_type;

  // On-width in sixteenths for each dimmer code, ascending
  function automatic logic [4:0] dim_width(input logic [2:0] code);
    case (code)
      3'h0:    dim_width = 5'h01;
      3'h1:    dim_width = 5'h02;
      3'h2:    dim_width = 5'h04;
      3'h3:    dim_width = 5'h0a;
      3'h4:    dim_width = 5'h0b;
      3'h5:    dim_width = 5'h0c;
      3'h6:    dim_width = 5'h0d;
      default: dim_width = 5'h0e;
    endcase
  endfunction : dim_width

endpackage : vfd_pkg

// file: core/vfd_controller.sv
// Display controller: serial receiver, display RAM, dimmer, key scan
`timescale 1ns/1ps
module vfd_controller
  import vfd_pkg::*;
#(
  parameter int unsigned SECT_CYC = 64  // Reference cycles per PWM section
) (
  input  wire logic                   i_ref_clk,             // Core clock
  input  wire logic                   i_rst,                 // Async reset, high
  input  wire logic                   i_serial_clk,          // Link clock from host
  input  wire logic                   i_select_n,            // Link select, low active
  input  wire logic                   i_serial_data_in,      // Link data in
  output logic                        o_serial_data_out,     // Link data out level
  output logic                        o_serial_data_oe,      // Link data out drive
  input  wire logic                   i_key_return_a,        // Key return line a
  input  wire logic                   i_key_return_b,        // Key return line b
  output logic [STROBES-1:0]          o_segment_key_strobe,  // Segment 1-16 / key strobe
  output logic [SHARED_PINS-1:0]      o_segment_grid_shared, // Segment 17-24 / grid 12-5
  output logic [GRID_PINS-1:0]        o_digit_row,           // Grid 1-4
  output logic [LED_PINS-1:0]         o_indicator_outputs    // LEDs, low lights
);

  localparam int unsigned TW = $clog2(SECT_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(SECT_CYC - 1);

  // ****************************************************************
  // Link domain state
  // ****************************************************************
  // Frame part is cleared whenever select is high, so a stopped link
  // clock cannot leave a half byte behind.
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic       first;
    logic       rd;
  } vfd_lframe_type;

  // Hand-over part survives select so the toggle never jumps
  typedef struct packed {
    logic [7:0] byte_v;
    logic       cmd;
    logic       tog;
  } vfd_lhold_type;

  typedef struct packed {
    logic [KEY_BITS-1:0] sh;
    logic                loaded;
    logic                oe;
    logic                dout;
  } vfd_lout_type;

  // ****************************************************************
  // Core domain state
  // ****************************************************************
  typedef struct packed {
    logic [RAM_BYTES-1:0][7:0]  ram;
    logic [5:0]                 addr;
    logic                       fixed;
    logic [1:0]                 op;
    logic [3:0]                 mode;
    logic                       disp_on;
    logic [2:0]                 dim;
    logic [3:0]                 led;
    logic                       sel_s1;
    logic                       sel_s2;
    logic                       tog_s1;
    logic                       tog_s2;
    logic                       tog_s3;
    logic                       ka_s1;
    logic                       ka_s2;
    logic                       kb_s1;
    logic                       kb_s2;
    vfd_scan_type               st;
    logic [3:0]                 digit;
    logic [3:0]                 section;
    logic [TW-1:0]              tick;
    logic                       half;
    logic [KEY_BITS-1:0]        keys;
    logic [KEY_BITS-1:0]        key_pub;
    logic [STROBES-1:0]         o_strobe;
    logic [SHARED_PINS-1:0]     o_shared;
    logic [GRID_PINS-1:0]       o_grid;
    logic [LED_PINS-1:0]        o_led;
  } vfd_core_type;

  vfd_lframe_type lf_q, lf_d;
  vfd_lhold_type  lh_q, lh_d;
  vfd_lout_type   lo_q, lo_d;
  vfd_core_type   c_q, c_d;
  logic           frame_rst;

  // ****************************************************************
  // Link receiver, rising edge of the link clock
  // ****************************************************************
  assign frame_rst = i_rst | i_select_n;

  always_comb
  begin
    lf_d = lf_q;
    lh_d = lh_q;
    lf_d.sh  = {i_serial_data_in, lf_q.sh[7:1]};
    lf_d.cnt = 3'(lf_q.cnt + 3'h1);
    if (lf_q.cnt == BIT_LAST)
    begin
      lf_d.first = 1'b0;
      // Bytes clocked during a key read carry nothing
      if (!lf_q.rd)
      begin
        lh_d.byte_v = lf_d.sh;
        lh_d.cmd    = lf_q.first;
        lh_d.tog    = ~lh_q.tog;
      end
      if (lf_q.first && lf_d.sh[CMD_HI:CMD_LO] == CMD_DATA &&
          lf_d.sh[OP_HI:0] == OP_READ_KEY)
      begin
        lf_d.rd = 1'b1;
      end
    end
  end

  always_ff @(posedge i_serial_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      lf_q <= '{sh: 8'h00, cnt: 3'h0, first: 1'b1, rd: 1'b0};
    end
    else
    begin
      lf_q <= lf_d;
    end
  end

  always_ff @(posedge i_serial_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lh_q <= '{byte_v: 8'h00, cmd: 1'b0, tog: 1'b0};
    end
    else
    begin
      lh_q <= lh_d;
    end
  end

  // ****************************************************************
  // Link transmitter, falling edge of the link clock
  // ****************************************************************
  // The published key word only changes while select is high, so it
  // is static for the whole read frame.
  always_comb
  begin
    lo_d = lo_q;
    lo_d.dout = 1'b0;
    if (lf_q.rd && !lo_q.loaded)
    begin
      lo_d.loaded = 1'b1;
      lo_d.oe     = ~c_q.key_pub[0];
      // Ones fill in behind the key bits so the line is released after bit 31
      lo_d.sh     = {1'b1, c_q.key_pub[KEY_BITS-1:1]};
    end
    else if (lo_q.loaded)
    begin
      lo_d.oe = ~lo_q.sh[0];
      lo_d.sh = {1'b1, lo_q.sh[KEY_BITS-1:1]};
    end
  end

  always_ff @(negedge i_serial_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      lo_q <= '{sh: '0, loaded: 1'b0, oe: 1'b0, dout: 1'b0};
    end
    else
    begin
      lo_q <= lo_d;
    end
  end

  assign o_serial_data_out = lo_q.dout;
  assign o_serial_data_oe  = lo_q.oe;

  // ****************************************************************
  // Core: command decode, RAM, scan and outputs
  // ****************************************************************
  logic                rx_ev;
  logic [3:0]          mode_new;
  logic [3:0]          digits;
  logic [3:0]          kidx;
  logic [4:0]          width;
  logic                grid_on;
  logic [23:0]         segs;

  assign rx_ev    = c_q.tog_s2 ^ c_q.tog_s3;
  assign mode_new = (lh_q.byte_v[MODE_HI:0] > MODE_MAX) ? MODE_MAX : lh_q.byte_v[MODE_HI:0];
  assign digits   = 4'(c_q.mode + DIG_BASE);
  assign kidx     = {c_q.half, c_q.section[3:1]};
  assign width    = dim_width(c_q.dim);
  assign grid_on  = (c_q.st == ST_GRID) && ({1'b0, c_q.section} < width);

  always_comb
  begin
    int base;
    base = int'(c_q.digit) * int'(ROW_BYTES);
    segs = '0;
    for (int b = 0; b < int'(ROW_BYTES); b++)
    begin
      if (base + b < int'(RAM_BYTES))
      begin
        segs[8*b +: 8] = c_q.ram[base + b];
      end
    end
  end

  always_comb
  begin
    c_d = c_q;
    c_d.sel_s1 = i_select_n;
    c_d.sel_s2 = c_q.sel_s1;
    c_d.tog_s1 = lh_q.tog;
    c_d.tog_s2 = c_q.tog_s1;
    c_d.tog_s3 = c_q.tog_s2;
    c_d.ka_s1  = i_key_return_a;
    c_d.ka_s2  = c_q.ka_s1;
    c_d.kb_s1  = i_key_return_b;
    c_d.kb_s2  = c_q.kb_s1;

    if (rx_ev && lh_q.cmd)
    begin
      case (lh_q.byte_v[CMD_HI:CMD_LO])
        CMD_MODE:
        begin
          if (mode_new != c_q.mode)
          begin
            c_d.mode    = mode_new;
            c_d.disp_on = 1'b0;
          end
        end
        CMD_DATA:
        begin
          c_d.op    = lh_q.byte_v[OP_HI:0];
          c_d.fixed = lh_q.byte_v[FIXED_BIT];
        end
        CMD_CTRL:
        begin
          c_d.disp_on = lh_q.byte_v[ON_BIT];
          c_d.dim     = lh_q.byte_v[DIM_HI:0];
        end
        default:
        begin
          c_d.addr = lh_q.byte_v[ADDR_HI:0];
        end
      endcase
    end
    else if (rx_ev)
    begin
      if (c_q.op == OP_WRITE_RAM && c_q.addr < ADDR_LIMIT)
      begin
        c_d.ram[c_q.addr] = lh_q.byte_v;
        if (!c_q.fixed)
        begin
          c_d.addr = 6'(c_q.addr + 6'h01);
        end
      end
      else if (c_q.op == OP_WRITE_LED)
      begin
        c_d.led = lh_q.byte_v[LED_HI:0];
      end
    end

    // Scan sequencer: digits then one key slot per frame
    c_d.tick = (c_q.tick == TICK_LAST) ? '0 : TW'(c_q.tick + 1'b1);
    if (c_q.tick == TICK_LAST)
    begin
      c_d.section = 4'(c_q.section + 4'h1);
    end
    case (c_q.st)
      ST_IDLE:
      begin
        c_d.st = ST_GRID;
      end
      ST_GRID:
      begin
        if (c_q.tick == TICK_LAST && c_q.section == SEC_LAST)
        begin
          if (c_q.digit == 4'(digits - 4'h1))
          begin
            c_d.digit = 4'h0;
            c_d.st    = ST_KEY;
          end
          else
          begin
            c_d.digit = 4'(c_q.digit + 4'h1);
          end
        end
      end
      ST_KEY:
      begin
        if (c_q.tick == TICK_LAST && c_q.section[0])
        begin
          c_d.keys[{kidx, 1'b0}] = c_q.ka_s2;
          c_d.keys[{kidx, 1'b1}] = c_q.kb_s2;
        end
        if (c_q.tick == TICK_LAST && c_q.section == SEC_LAST)
        begin
          c_d.half = ~c_q.half;
          c_d.st   = ST_GRID;
        end
      end
      default:
      begin
        c_d.st = ST_IDLE;
      end
    endcase
    if (!c_q.disp_on)
    begin
      c_d.st      = ST_IDLE;
      c_d.tick    = '0;
      c_d.section = 4'h0;
      c_d.digit   = 4'h0;
      c_d.half    = 1'b0;
    end
    // Publish keys only while the link is idle
    if (c_q.sel_s2)
    begin
      c_d.key_pub = c_q.keys;
    end

    // Registered outputs
    c_d.o_strobe = '0;
    if (c_q.st == ST_KEY)
    begin
      c_d.o_strobe = STROBE_ONE << kidx;
    end
    else if (grid_on)
    begin
      c_d.o_strobe = segs[STROBES-1:0];
    end
    for (int i = 0; i < int'(SHARED_PINS); i++)
    begin
      if (i < int'(SHARED_PINS) - int'(c_q.mode))
      begin
        c_d.o_shared[i] = grid_on & segs[int'(STROBES) + i];
      end
      else
      begin
        c_d.o_shared[i] = grid_on && (int'(c_q.digit) == GRID_TOP - i);
      end
    end
    for (int g = 0; g < int'(GRID_PINS); g++)
    begin
      c_d.o_grid[g] = grid_on && (int'(c_q.digit) == g);
    end
    c_d.o_led = c_q.led;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      c_q         <= '0;
      c_q.addr    <= ADDR_RESET;
      c_q.mode    <= MODE_RESET;
      c_q.dim     <= DIM_RESET;
      c_q.op      <= OP_WRITE_RAM;
      c_q.led     <= LED_RESET;
      c_q.o_led   <= LED_RESET;
      c_q.sel_s1  <= 1'b1;
      c_q.sel_s2  <= 1'b1;
      c_q.st      <= ST_IDLE;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  assign o_segment_key_strobe  = c_q.o_strobe;
  assign o_segment_grid_shared = c_q.o_shared;
  assign o_digit_row           = c_q.o_grid;
  assign o_indicator_outputs   = c_q.o_led;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_grid_off_width: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (c_q.st == ST_GRID && {1'b0, c_q.section} >= width) |=> o_digit_row == '0)
    else $error("Grid driven outside its on-width");

  a_grid_on_width: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (c_q.st == ST_GRID && c_q.digit == 4'h0 && c_q.section == 4'h0) |=> o_digit_row[0])
    else $error("First grid not lit in first section");

  a_mode_blank: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_ev && lh_q.cmd && lh_q.byte_v[CMD_HI:CMD_LO] == CMD_MODE && mode_new != c_q.mode)
    |=> !c_q.disp_on ##1 (c_q.st == ST_IDLE) ##1 (o_segment_key_strobe == '0))
    else $error("Mode change did not blank the display");

  a_same_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_ev && lh_q.cmd && lh_q.byte_v[CMD_HI:CMD_LO] == CMD_MODE && mode_new == c_q.mode)
    |=> $stable(c_q.disp_on) && $stable(c_q.mode))
    else $error("Repeated mode command changed state");

  a_addr_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_ev && !lh_q.cmd && c_q.op == OP_WRITE_RAM && c_q.addr < ADDR_LIMIT)
    |=> c_q.addr == ($past(c_q.fixed) ? $past(c_q.addr) : 6'($past(c_q.addr) + 6'h01)))
    else $error("Address step wrong after data byte");

  a_addr_ignore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_ev && !lh_q.cmd && c_q.addr >= ADDR_LIMIT) |=> $stable(c_q.ram) && $stable(c_q.addr))
    else $error("Data accepted at out-of-range address");

  a_led_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rx_ev && !lh_q.cmd && c_q.op == OP_WRITE_LED)
    |=> ##1 o_indicator_outputs == $past(lh_q.byte_v[LED_HI:0], 2))
    else $error("LED port not updated from low nibble");

  a_key_sample: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (c_q.st == ST_KEY && c_q.tick == TICK_LAST && c_q.section[0] && c_q.disp_on)
    |=> c_q.keys[{$past(kidx), 1'b1}] == $past(c_q.kb_s2))
    else $error("Key return b not stored at its strobe");

  a_read_load: assert property (@(negedge i_serial_clk) disable iff (frame_rst)
    (lf_q.rd && !lo_q.loaded) |=> lo_q.loaded && (o_serial_data_oe == ~$past(c_q.key_pub[0])))
    else $error("Read did not present key bit zero");

  c_mode_change: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    rx_ev && lh_q.cmd && lh_q.byte_v[CMD_HI:CMD_LO] == CMD_MODE && mode_new != c_q.mode);
  c_key_cycle: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    c_q.st == ST_KEY && c_q.half && c_q.section == SEC_LAST);
  c_led_write: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    rx_ev && !lh_q.cmd && c_q.op == OP_WRITE_LED);
  c_read_start: cover property (@(negedge i_serial_clk) disable iff (frame_rst)
    lf_q.rd && !lo_q.loaded);

endmodule : vfd_controller

// file: tb/vfd_host.sv
// Host model driving the serial link of the display controller
`timescale 1ns/1ps
module vfd_host (
  input  wire logic i_data_line,  // Wired data line, pulled up
  output logic      o_serial_clk, // Link clock, still between frames
  output logic      o_select_n,   // Select, low active
  output logic      o_data        // Serial data to the device
);
  initial
  begin
    o_serial_clk = 1'b1;
    o_select_n   = 1'b1;
    o_data       = 1'b0;
  end

  task automatic open_frame();
    o_select_n = 1'b0;
    #15;
  endtask : open_frame

  // Released line shows the inverse so a stale bit is never mistaken for data
  task automatic close_frame();
    #15;
    o_select_n = 1'b1;
    o_data     = ~o_data;
    #60;
  endtask : close_frame

  // Bits go out LSB first and change only while the clock is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      o_serial_clk = 1'b0;
      o_data       = b[i];
      #7.5 o_serial_clk = 1'b1;
      #7.5;
    end
  endtask : send_bits

  task automatic read_keys(output logic [31:0] k);
    open_frame();
    send_bits(8'h42, 8);
    o_serial_clk = 1'b0;
    #1000;
    for (int i = 0; i < 32; i++)
    begin
      k[i]         = i_data_line;
      o_serial_clk = 1'b1;
      #7.5 o_serial_clk = 1'b0;
      #7.5;
    end
    o_serial_clk = 1'b1;
    close_frame();
  endtask : read_keys
endmodule : vfd_host

// file: tb/vfd_controller_bench.sv
// Self-checking bench for the display controller
`timescale 1ns/1ps
module vfd_controller_bench;
  localparam int SC = 4;
  logic        clk, rst, ka, kb, sclk, sel_n, sdi, sdo, soe;
  logic [15:0] seg, pat_a, pat_b;
  logic [7:0]  shr, shr_at;
  logic [3:0]  dig, led;
  int          fail_count, num_checks;
  wire         line = soe ? sdo : 1'b1;
  int          wid [8] = '{1, 2, 4, 10, 11, 12, 13, 14};

  vfd_controller #(.SECT_CYC(SC)) u_vfd_controller (
    .i_ref_clk(clk), .i_rst(rst), .i_serial_clk(sclk), .i_select_n(sel_n),
    .i_serial_data_in(sdi), .o_serial_data_out(sdo), .o_serial_data_oe(soe),
    .i_key_return_a(ka), .i_key_return_b(kb), .o_segment_key_strobe(seg),
    .o_segment_grid_shared(shr), .o_digit_row(dig), .o_indicator_outputs(led));

  vfd_host u_vfd_host (.i_data_line(line), .o_serial_clk(sclk),
    .o_select_n(sel_n), .o_data(sdi));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Key matrix: a return line is high while a strobe of a pressed key is up
  always @(negedge clk)
  begin
    ka <= |(seg & pat_a);
    kb <= |(seg & pat_b);
  end

  // ********
  // Shared tasks
  // ********
  task automatic check(input string what, input logic [31:0] exp, seen);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic send(input logic [7:0] q [$]);
    u_vfd_host.open_frame();
    foreach (q[i])
      u_vfd_host.send_bits(q[i], 8);
    u_vfd_host.close_frame();
    repeat (10) @(posedge clk);
  endtask : send

  // Length of one whole pulse of grid g and the segments shown in it
  task automatic pulse(input int g, output int n, output logic [15:0] s);
    int t;
    t = 0;
    n = 0;
    s = 16'h0;
    while (dig[g] === 1'b1 && t < 4000)
    begin
      @(negedge clk);
      t++;
    end
    while (dig[g] !== 1'b1 && t < 4000)
    begin
      @(negedge clk);
      t++;
    end
    s = seg;
    shr_at = shr;
    while (dig[g] === 1'b1 && t < 4000)
    begin
      @(negedge clk);
      n++;
      t++;
    end
  endtask : pulse

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    int n;
    logic [15:0] s;
    check("led after reset", 4'hf, led);
    check("oe after reset", 1'b0, soe);
    pulse(0, n, s);
    check("grid while off", 0, n);
  endtask : t_reset

  task automatic t_led();
    send('{8'h41, 8'ha5});
    check("led byte", 4'h5, led);
    u_vfd_host.open_frame();
    u_vfd_host.send_bits(8'h41, 8);
    u_vfd_host.send_bits(8'h00, 5);
    u_vfd_host.close_frame();
    repeat (10) @(posedge clk);
    check("led after abort", 4'h5, led);
    send('{8'h41, 8'hfa});
    check("led second", 4'ha, led);
  endtask : t_led

  task automatic t_ram();
    int n;
    logic [15:0] s;
    send('{8'h40});
    send('{8'hc0, 8'h34, 8'h12, 8'h56});
    send('{8'hc3, 8'h33, 8'h44});
    send('{8'h8f});
    pulse(0, n, s);
    check("digit one segs", 16'h1234, s);
    check("width code 7", 14 * SC, n);
    send('{8'h44});
    send('{8'hc3, 8'h11, 8'h22});
    pulse(1, n, s);
    check("fixed address", 16'h4422, s);
    send('{8'h40});
    send('{8'he4, 8'h99, 8'h99});
    pulse(0, n, s);
    check("high address", 16'h1234, s);
  endtask : t_ram

  task automatic t_dim();
    int n;
    logic [15:0] s;
    for (int c = 0; c < 8; c++)
    begin
      send('{8'h88 | 8'(c)});
      pulse(0, n, s);
      check("dim width", wid[c] * SC, n);
    end
  endtask : t_dim

  task automatic t_mode();
    int n;
    logic [15:0] s;
    send('{8'h08});
    pulse(0, n, s);
    check("same mode", 14 * SC, n);
    send('{8'h00});
    pulse(0, n, s);
    check("new mode off", 0, n);
    send('{8'h8f});
    pulse(0, n, s);
    check("wide segs", 8'h56, shr_at);
    send('{8'h08});
    send('{8'h8f});
    pulse(0, n, s);
    check("display back", 14 * SC, n);
  endtask : t_mode

  task automatic t_keys();
    logic [31:0] k, e;
    for (int i = 0; i < 16; i++)
    begin
      e[2*i]   = pat_a[i];
      e[2*i+1] = pat_b[i];
    end
    repeat (1800) @(posedge clk);
    u_vfd_host.read_keys(k);
    check("key matrix", e, k);
    check("oe released", 1'b0, soe);
    check("data out level", 1'b0, sdo);
  endtask : t_keys

  // Full refresh: mode, data setting, address, 36 bytes, display control
  task automatic t_refresh();
    logic [7:0]  q [$];
    logic [15:0] s;
    int          n;
    q = '{8'hc0};
    for (int i = 0; i < 36; i++)
      q.push_back(8'(i + 1));
    send('{8'h08});
    send('{8'h40});
    send(q);
    send('{8'h8f});
    pulse(0, n, s);
    check("refresh first row", 16'h0201, s);
    n = 0;
    while (shr[0] !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check("refresh last row", 16'h2322, seg);
  endtask : t_refresh

  initial
  begin
    rst        = 1'b1;
    pat_a      = 16'hc35a;
    pat_b      = 16'h0ff1;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    check("led in reset", 4'hf, led);
    check("grid in reset", 4'h0, dig);
    @(negedge clk) rst = 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_led();
    t_ram();
    t_dim();
    t_mode();
    t_refresh();
    t_keys();
    report_and_stop();
  end

  // Run needs roughly 24k cycles; this cuts a hang well past that
  initial
  begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule : vfd_controller_bench
